// ===== hdl/sadc_dev.sv
// Converter device end: serial port, mux control and conversion sequence
//
// Notes on behaviour
// R1: Accepted interface reset aborts running conversion
// R2: Host never drops select during conversion
// R3: Result leaves MSB first on falling clock
// R4: Output released after eighth clock regardless
// R5: Address MSB first, sampled on rising clock
// R6: Shift register static, any clock rate; here sclk is sampled on i_ref_clk, each level must last over one cycle
// R7: Exactly eight clocks per transfer
// R8: Address first four clocks, sampling last four
// R9: Shift clock ignored until conversion ends
// R10: External conversion clock runs free, unrelated
// R11: Done output falls on eighth falling edge
// R12: Done output rises when result ready
// R13: Codes 0 to A select channels 0-10
// R14: Code B converts to midpoint 80 hex
// R15: Mux breaks before it makes
// R16: Host counts 32 conversion clocks before read
// R17: Out goes previous result, in next address
// R18: Host services rising done as interrupt
// R19: Select high keeps output released
// R20: Select falling edge resyncs bit counting
// R21: Short select pulses ignored, long accepted
// R22: Accepted reset restarts the bit counter
`timescale 1ns/1ps
module sadc_dev #(
  parameter bit INT_CLK = 1'b1
) (
  // Clock, reset, enable
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rstn,
  input  wire logic                         i_ce,
  // Link pins
  sadc_link_if.dev                          link,
  // Analog front end
  output      logic [sadc_pkg::ADDR_W-1:0]  o_mux_sel,
  output      logic                         o_mux_on,
  output      logic                         o_sampling,
  output      logic                         o_converting,
  input  wire logic [sadc_pkg::DATA_W-1:0]  i_code
);

  // Whole state of the device end
  typedef struct packed {
    logic                        cs_s1;
    logic                        cs_s2;
    logic                        sclk_s1;
    logic                        sclk_s2;
    logic                        sclk_p;
    logic                        din_s1;
    logic                        din_s2;
    logic                        cclk_s1;
    logic                        cclk_s2;
    logic                        cclk_p;
    sadc_pkg::sadc_dev_st_t      st;
    logic [3:0]                  bit_cnt;
    logic [sadc_pkg::ADDR_W-1:0] addr_sh;
    logic [sadc_pkg::ADDR_W-1:0] mux_sel;
    logic                        mux_on;
    logic                        mux_pend;
    logic                        sampling;
    logic [sadc_pkg::DATA_W-1:0] res;
    logic [sadc_pkg::DATA_W-1:0] res_sh;
    logic                        dout_off;
    logic                        oe;
    logic                        busy;
    logic [6:0]                  tick_cnt;
    logic [4:0]                  conv_cnt;
    logic [1:0]                  cs_cnt;
    logic                        cs_taken;
  } sadc_dev_state_t;

  sadc_dev_state_t q;
  sadc_dev_state_t d;

  localparam logic [6:0] TICK_LAST = 7'(sadc_pkg::INT_TICK_CYC - 1);
  localparam logic [4:0] CONV_LAST = 5'(sadc_pkg::CONV_TICKS - 1);
  localparam logic [1:0] CS_LAST   = 2'(sadc_pkg::CS_ACCEPT_TICKS - 1);
  localparam logic [3:0] ADDR_LAST = 4'(sadc_pkg::ADDR_BITS - 1);
  localparam logic [3:0] XFER_LAST = 4'(sadc_pkg::XFER_BITS - 1);

  // Code a finished conversion yields for the selected input
  function automatic logic [sadc_pkg::DATA_W-1:0] conv_code(
    input logic [sadc_pkg::ADDR_W-1:0] sel,
    input logic [sadc_pkg::DATA_W-1:0] code
  );
    if (sel <= sadc_pkg::LAST_CHAN) begin
      conv_code = code; // R13
    end else if (sel == sadc_pkg::TEST_CHAN) begin
      conv_code = sadc_pkg::TEST_CODE; // R14
    end else begin
      conv_code = sadc_pkg::NONE_CODE;
    end
  endfunction

  logic sclk_rise;
  logic sclk_fall;
  logic tick;
  logic if_reset;

  // Edge detection on synchronised pins and conversion tick
  always_comb begin
    sclk_rise = q.sclk_s2 & ~q.sclk_p;
    sclk_fall = ~q.sclk_s2 & q.sclk_p;
    if (INT_CLK) begin
      tick = (q.tick_cnt == TICK_LAST);
    end else begin
      tick = q.cclk_s2 & ~q.cclk_p; // R10
    end
    if_reset = ~q.cs_s2 & ~q.cs_taken & tick & (q.cs_cnt == CS_LAST);
  end

  // Next-state logic
  always_comb begin
    d = q;
    // Pin synchronisers
    d.cs_s1   = link.cs_n;
    d.cs_s2   = q.cs_s1;
    d.sclk_s1 = link.sclk; // R6
    d.sclk_s2 = q.sclk_s1;
    d.sclk_p  = q.sclk_s2;
    d.din_s1  = link.din;
    d.din_s2  = q.din_s1;
    d.cclk_s1 = link.conv_clk;
    d.cclk_s2 = q.cclk_s1;
    d.cclk_p  = q.cclk_s2;

    // Internal conversion clock divider
    d.tick_cnt = tick ? 7'h00 : q.tick_cnt + 7'h01;

    // Select glitch filter counts conversion ticks while low
    if (q.cs_s2) begin
      d.cs_cnt   = 2'h0;
      d.cs_taken = 1'b0;
    end else if (if_reset) begin
      d.cs_taken = 1'b1; // R21
    end else if (tick && !q.cs_taken) begin
      d.cs_cnt = q.cs_cnt + 2'h1; // R21
    end

    // Mux reconnects one cycle after disconnecting
    if (q.mux_pend) begin
      d.mux_on   = 1'b1; // R15
      d.mux_pend = 1'b0;
    end

    unique case (q.st)
      sadc_pkg::SADC_IDLE,
      sadc_pkg::SADC_SHIFT: begin
        if (sclk_rise) begin
          d.st = sadc_pkg::SADC_SHIFT;
          if (q.bit_cnt <= ADDR_LAST) begin
            d.addr_sh = {q.addr_sh[2:0], q.din_s2}; // R5
          end
          if (q.bit_cnt == ADDR_LAST) begin
            d.mux_sel  = {q.addr_sh[2:0], q.din_s2}; // R8
            d.mux_on   = 1'b0; // R15
            d.mux_pend = 1'b1;
          end
        end
        if (sclk_fall) begin
          d.st      = sadc_pkg::SADC_SHIFT;
          d.bit_cnt = q.bit_cnt + 4'h1; // R7
          d.res_sh  = {q.res_sh[6:0], 1'b0}; // R3
          if (q.bit_cnt == ADDR_LAST) begin
            d.sampling = 1'b1; // R8
          end
          if (q.bit_cnt == XFER_LAST) begin
            d.st       = sadc_pkg::SADC_CONV;
            d.bit_cnt  = 4'h0;
            d.sampling = 1'b0;
            d.dout_off = 1'b1; // R4
            d.busy     = 1'b1; // R11
            d.conv_cnt = 5'h00;
          end
        end
      end
      sadc_pkg::SADC_CONV: begin
        // Shift clock edges are not looked at here
        if (tick) begin // R9
          d.conv_cnt = q.conv_cnt + 5'h01;
          if (q.conv_cnt == CONV_LAST) begin
            d.st = sadc_pkg::SADC_DONE;
          end
        end
      end
      sadc_pkg::SADC_DONE: begin
        d.res      = conv_code(q.mux_sel, i_code); // R17
        d.res_sh   = conv_code(q.mux_sel, i_code);
        d.busy     = 1'b0; // R12
        d.dout_off = 1'b0;
        d.st       = sadc_pkg::SADC_IDLE;
      end
    endcase

    // Accepted select edge restarts the serial port
    if (if_reset) begin // R20
      d.st       = sadc_pkg::SADC_IDLE; // R1
      d.busy     = 1'b0; // R1
      d.bit_cnt  = 4'h0; // R22
      d.sampling = 1'b0;
      d.dout_off = 1'b0;
      d.conv_cnt = 5'h00;
      d.res_sh   = q.res;
    end

    // Output drives only after an accepted select, never after reset
    d.oe = d.cs_taken & ~q.cs_s2 & ~d.dout_off; // R19
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // Pin and front-end outputs
  assign link.dout    = q.res_sh[sadc_pkg::DATA_W-1]; // R3
  assign link.dout_oe = q.oe; // R4
  assign link.done    = ~q.busy; // R11
  assign o_mux_sel    = q.mux_sel;
  assign o_mux_on     = q.mux_on;
  assign o_sampling   = q.sampling;
  assign o_converting = q.busy;

endmodule

// ===== hdl/sadc_pkg.sv
// Shared constants and types for the serial converter link, both ends
package sadc_pkg;

  // Link geometry
  localparam int ADDR_W     = 4;
  localparam int DATA_W     = 8;
  localparam int XFER_BITS  = 8;
  localparam int ADDR_BITS  = 4;

  // Reference clock
  localparam int CLK_PERIOD_NS = 10;

  // Conversion length in conversion-clock periods
  localparam int CONV_TICKS      = 20;
  // Conversion-clock periods the host counts before reading
  localparam int HOST_CONV_WAIT  = 32;
  // Conversion-clock edges chip select must stay low to be accepted
  localparam int CS_ACCEPT_TICKS = 2;

  // Internal conversion clock period of the done-output variant
  localparam int INT_TICK_NS  = 1000;
  localparam int INT_TICK_CYC = INT_TICK_NS / CLK_PERIOD_NS;

  // Host pin timing
  localparam int SCLK_HALF_NS  = 500;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CCLK_HALF_NS  = 250;
  localparam int CCLK_HALF_CYC = (CCLK_HALF_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CS_SETUP_NS   = 4000;
  localparam int CS_SETUP_CYC  = (CS_SETUP_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  // Channel codes
  localparam logic [3:0] LAST_CHAN = 4'hA;
  localparam logic [3:0] TEST_CHAN = 4'hB;
  localparam logic [7:0] TEST_CODE = 8'h80;
  localparam logic [7:0] NONE_CODE = 8'h00;

  // Device states, Gray along the path
  typedef enum logic [1:0] {
    SADC_IDLE  = 2'h0,
    SADC_SHIFT = 2'h1,
    SADC_CONV  = 2'h3,
    SADC_DONE  = 2'h2
  } sadc_dev_st_t;

  // Host states, Gray along the path
  typedef enum logic [1:0] {
    SADC_H_IDLE  = 2'h0,
    SADC_H_SETUP = 2'h1,
    SADC_H_SHIFT = 2'h3,
    SADC_H_WAIT  = 2'h2
  } sadc_host_st_t;

endpackage

// ===== hdl/sadc_link_if.sv
// Pin-level link between the converter device and its host
`timescale 1ns/1ps
interface sadc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic conv_clk;
  logic dout;
  logic dout_oe;
  logic done;
  logic dout_pin;

  // Released serial output reads high, as with a pull-up
  assign dout_pin = dout_oe ? dout : 1'b1;

  modport dev (
    input  cs_n,
    input  sclk,
    input  din,
    input  conv_clk,
    output dout,
    output dout_oe,
    output done
  );

  modport host (
    output cs_n,
    output sclk,
    output din,
    output conv_clk,
    input  dout_pin,
    input  done
  );
endinterface

// ===== hdl/sadc_host.sv
// Host end: drives the serial port and buffers returned results
`timescale 1ns/1ps
module sadc_host #(
  parameter bit INT_CLK = 1'b1
) (
  // Clock, reset, enable
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rstn,
  input  wire logic                         i_ce,
  // Link pins
  sadc_link_if.host                         link,
  // Conversion requests
  input  wire logic                         i_req_valid,
  input  wire logic [sadc_pkg::ADDR_W-1:0]  i_req_addr,
  output      logic                         o_req_ready,
  // Returned results
  output      logic                         o_rx_valid,
  output      logic [sadc_pkg::DATA_W-1:0]  o_rx_data,
  input  wire logic                         i_rx_ready
);

  // Whole state of the host end
  typedef struct packed {
    sadc_pkg::sadc_host_st_t          st;
    logic [11:0]                      cnt;
    logic                             sclk;
    logic                             cs_act;
    logic                             din;
    logic [3:0]                       bit_cnt;
    logic [sadc_pkg::ADDR_W-1:0]      tx_sh;
    logic [sadc_pkg::DATA_W-1:0]      rx_sh;
    logic [11:0]                      cdiv;
    logic                             cclk;
    logic [5:0]                       ccnt;
    logic                             dout_s1;
    logic                             dout_s2;
    logic                             done_s1;
    logic                             done_s2;
    logic                             done_p;
    logic [1:0][sadc_pkg::DATA_W-1:0] mem;
    logic                             wr_ptr;
    logic                             rd_ptr;
    logic [1:0]                       count;
  } sadc_host_state_t;

  sadc_host_state_t q;
  sadc_host_state_t d;

  localparam logic [11:0] SETUP_LAST = 12'(sadc_pkg::CS_SETUP_CYC - 1);
  localparam logic [11:0] SHALF_LAST = 12'(sadc_pkg::SCLK_HALF_CYC - 1);
  localparam logic [11:0] CHALF_LAST = 12'(sadc_pkg::CCLK_HALF_CYC - 1);
  localparam logic [5:0]  WAIT_LAST  = 6'(sadc_pkg::HOST_CONV_WAIT - 1);
  localparam logic [3:0]  XFER_LAST  = 4'(sadc_pkg::XFER_BITS - 1);

  logic cclk_rise;
  logic push;
  logic pop;

  // Handshake terms
  always_comb begin
    cclk_rise   = (q.cdiv == CHALF_LAST) & ~q.cclk;
    o_req_ready = (q.st == sadc_pkg::SADC_H_IDLE) & (q.count != 2'h2);
    o_rx_valid  = (q.count != 2'h0);
    pop         = o_rx_valid & i_rx_ready;
    push        = (q.st == sadc_pkg::SADC_H_SHIFT) & q.sclk
                  & (q.cnt == SHALF_LAST) & (q.bit_cnt == XFER_LAST);
  end

  // Next-state logic
  always_comb begin
    d = q;
    d.dout_s1 = link.dout_pin;
    d.dout_s2 = q.dout_s1;
    d.done_s1 = link.done;
    d.done_s2 = q.done_s1;
    d.done_p  = q.done_s2;

    // Free-running conversion clock
    if (q.cdiv == CHALF_LAST) begin
      d.cdiv = 12'h000;
      d.cclk = ~q.cclk; // R10
    end else begin
      d.cdiv = q.cdiv + 12'h001;
    end

    unique case (q.st)
      sadc_pkg::SADC_H_IDLE: begin
        if (i_req_valid && o_req_ready) begin
          d.tx_sh  = i_req_addr;
          d.cs_act = 1'b1;
          d.cnt    = 12'h000;
          d.st     = sadc_pkg::SADC_H_SETUP;
        end
      end
      sadc_pkg::SADC_H_SETUP: begin
        d.cnt = q.cnt + 12'h001;
        if (q.cnt == SETUP_LAST) begin
          d.cnt     = 12'h000;
          d.bit_cnt = 4'h0;
          d.din     = q.tx_sh[3]; // R5
          d.st      = sadc_pkg::SADC_H_SHIFT;
        end
      end
      sadc_pkg::SADC_H_SHIFT: begin
        d.cnt = q.cnt + 12'h001;
        if (q.cnt == SHALF_LAST) begin
          d.cnt = 12'h000;
          if (!q.sclk) begin
            d.sclk  = 1'b1;
            d.rx_sh = {q.rx_sh[6:0], q.dout_s2};
          end else begin
            d.sclk    = 1'b0;
            d.bit_cnt = q.bit_cnt + 4'h1; // R7
            d.tx_sh   = {q.tx_sh[2:0], 1'b0};
            d.din     = q.tx_sh[2]; // R5
            if (q.bit_cnt == XFER_LAST) begin
              d.cs_act = 1'b0;
              d.din    = 1'b0;
              d.ccnt   = 6'h00;
              d.st     = sadc_pkg::SADC_H_WAIT;
            end
          end
        end
      end
      sadc_pkg::SADC_H_WAIT: begin
        // Select stays high until the conversion is over
        if (INT_CLK) begin
          if (q.done_s2 && !q.done_p) begin // R18
            d.st = sadc_pkg::SADC_H_IDLE; // R2
          end
        end else if (cclk_rise) begin
          d.ccnt = q.ccnt + 6'h01;
          if (q.ccnt == WAIT_LAST) begin
            d.st = sadc_pkg::SADC_H_IDLE; // R16
          end
        end
      end
    endcase

    // Two-entry result buffer
    if (push) begin
      d.mem[q.wr_ptr] = q.rx_sh; // R17
      d.wr_ptr        = ~q.wr_ptr;
    end
    if (pop) begin
      d.rd_ptr = ~q.rd_ptr;
    end
    d.count = q.count + {1'b0, push} - {1'b0, pop};
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // Pin and result outputs
  assign link.cs_n     = ~q.cs_act;
  assign link.sclk     = q.sclk;
  assign link.din      = q.din;
  assign link.conv_clk = q.cclk;
  assign o_rx_data     = q.mem[q.rd_ptr];

endmodule

// ===== testbench/sadc_link_properties.sv
// Link-level assertions watched beside the host-device interface
`timescale 1ns/1ps
module sadc_link_properties (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic done
);
  logic [3:0]  falls_q;
  logic [11:0] low_q;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  // Counts falling shift-clock edges within the current frame
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      falls_q <= 4'h0;
    end else if (cs_n) begin
      falls_q <= 4'h0;
    end else if ($fell(sclk)) begin
      falls_q <= falls_q + 4'h1;
    end
  end

  // Counts cycles that done has been low, saturating
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_q <= 12'h000;
    end else if (done) begin
      low_q <= 12'h000;
    end else if (low_q != 12'hFFF) begin
      low_q <= low_q + 12'h001;
    end
  end

  property p_oe_off_deselect;
    cs_n [*6] |-> !dout_oe;
  endproperty
  a_oe_off_deselect: assert property (p_oe_off_deselect)
    else $error("serial output driven while deselected");

  property p_dout_steady_high;
    dout_oe && $past(dout_oe) && sclk |-> $stable(dout);
  endproperty
  a_dout_steady_high: assert property (p_dout_steady_high)
    else $error("serial output moved while shift clock high");

  property p_oe_off_eighth;
    $fell(sclk) && falls_q == 4'h7 |-> ##[1:8] !dout_oe;
  endproperty
  a_oe_off_eighth: assert property (p_oe_off_eighth)
    else $error("serial output not released after eighth clock");

  property p_done_low_eighth;
    $fell(sclk) && falls_q == 4'h7 |-> ##[1:8] !done;
  endproperty
  a_done_low_eighth: assert property (p_done_low_eighth)
    else $error("done did not fall after eighth clock");

  property p_done_rises;
    $rose(done) |-> low_q >= 12'h708;
  endproperty
  a_done_rises: assert property (p_done_rises)
    else $error("conversion finished too early");

  property p_done_bound;
    !done |-> low_q <= 12'h898;
  endproperty
  a_done_bound: assert property (p_done_bound)
    else $error("conversion did not finish in time");

  property p_no_select_in_conv;
    !done |-> !$fell(cs_n);
  endproperty
  a_no_select_in_conv: assert property (p_no_select_in_conv)
    else $error("select dropped during conversion");

  property p_din_setup;
    $rose(sclk) |-> $stable(din);
  endproperty
  a_din_setup: assert property (p_din_setup)
    else $error("address bit moved at rising clock");

  property p_din_tail_zero;
    $rose(sclk) && falls_q >= 4'h4 |-> !din;
  endproperty
  a_din_tail_zero: assert property (p_din_tail_zero)
    else $error("data input not zero past address bits");

  property p_eight_per_frame;
    $rose(cs_n) |-> falls_q == 4'h7 && $fell(sclk);
  endproperty
  a_eight_per_frame: assert property (p_eight_per_frame)
    else $error("frame without exactly eight clocks");

  property p_oe_on_select;
    $fell(cs_n) |-> ##[90:260] dout_oe;
  endproperty
  a_oe_on_select: assert property (p_oe_on_select)
    else $error("select low not accepted in time");
endmodule

// ===== testbench/tb_serial_adc_host_interface.sv
// Testbench joining host and device ends over the serial link
`timescale 1ns/1ps
module tb_serial_adc_host_interface;
  logic       i_ref_clk = 1'b0;
  logic       i_rstn = 1'b0;
  logic       req_valid = 1'b0;
  logic [3:0] req_addr = 4'h0;
  logic       req_ready;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       rx_ready = 1'b0;
  logic [7:0] code = 8'h00;
  logic [3:0] mux_sel;
  logic       stall = 1'b1;
  logic [7:0] prev = 8'h00;
  logic [7:0] seen = 8'h00;
  logic [7:0] exp_q[$];
  int         err_total = 0;
  int         samples_checked = 0;

  sadc_link_if link ();
  sadc_link_if link_b ();

  // Both ends face each other; a second device meets a faulty host
  sadc_dev i_sadc_dev (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(1'b1), .link(link),
    .o_mux_sel(mux_sel), .o_mux_on(), .o_sampling(), .o_converting(),
    .i_code(code));
  sadc_dev i_sadc_dev_b (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(1'b1), .link(link_b),
    .o_mux_sel(), .o_mux_on(), .o_sampling(), .o_converting(),
    .i_code(code));
  sadc_host i_sadc_host (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(1'b1), .link(link),
    .i_req_valid(req_valid), .i_req_addr(req_addr), .o_req_ready(req_ready),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready));
  sadc_link_properties i_sadc_link_properties (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .cs_n(link.cs_n),
    .sclk(link.sclk), .din(link.din), .dout(link.dout),
    .dout_oe(link.dout_oe), .done(link.done));

  // Reference clock
  always #5 i_ref_clk = ~i_ref_clk;

  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic wait_clks(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // Bounded wait for the host to take a request
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
      if (n > 6000) begin
        err_total++;
        stop_test();
      end
    end while (req_ready !== 1'b1);
  endtask

  // One frame of eight shift clocks from the bench-side host
  task automatic frame_b(input logic [3:0] a);
    for (int i = 0; i < 8; i++) begin
      link_b.din <= (i < 4) ? a[3-i] : 1'b0;
      wait_clks(8);
      link_b.sclk <= 1'b1;
      seen[7-i] = link_b.dout_pin;
      wait_clks(8);
      link_b.sclk <= 1'b0;
    end
  endtask

  // Word expected back for an address and front-end code
  function automatic logic [7:0] result(input logic [3:0] a,
                                        input logic [7:0] c);
    if (a <= sadc_pkg::LAST_CHAN) return c;
    if (a == sadc_pkg::TEST_CHAN) return sadc_pkg::TEST_CODE;
    return sadc_pkg::NONE_CODE;
  endfunction

  // Result watcher: pops the oldest note at each accepted word
  always @(posedge i_ref_clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_q.size() > 0) check(rx_data, exp_q.pop_front());
      else err_total++;
    end
    rx_ready <= !stall && ($urandom_range(1, 0) == 1);
  end

  // Main sequence
  initial begin
    void'($urandom(91));
    link_b.cs_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.din = 1'b0;
    link_b.conv_clk = 1'b0;
    wait_clks(16);
    i_rstn <= 1'b1;
    link_b.cs_n <= 1'b0;
    wait_clks(40);
    check({7'h0, link_b.dout_oe}, 8'h00);
    link_b.cs_n <= 1'b1;
    wait_clks(300);
    check({7'h0, link_b.dout_oe}, 8'h00);
    link_b.cs_n <= 1'b0;
    wait_clks(400);
    check({7'h0, link_b.dout_oe}, 8'h01);
    frame_b(4'h5);
    check(seen, 8'h00);
    wait_clks(20);
    check({6'h0, link_b.done, link_b.dout_oe}, 8'h00);
    link_b.cs_n <= 1'b1;
    wait_clks(300);
    link_b.cs_n <= 1'b0;
    wait_clks(400);
    check({6'h0, link_b.done, link_b.dout_oe}, 8'h03);
    link_b.cs_n <= 1'b1;
    // Every address code, then random ones, with a full-buffer stall
    for (int k = 0; k < 18; k++) begin
      if (k == 2) begin
        wait_clks(4000);
        check({7'h0, req_ready}, 8'h00);
        stall <= 1'b0;
      end
      wait_rdy();
      check({4'h0, mux_sel}, {4'h0, req_addr});
      req_addr <= (k < 16) ? k[3:0] : 4'($urandom);
      code <= 8'($urandom);
      req_valid <= 1'b1;
      @(posedge i_ref_clk);
      req_valid <= 1'b0;
      exp_q.push_back(prev);
      prev = result(req_addr, code);
    end
    for (int n = 0; n < 5000 && exp_q.size() > 0; n++) begin
      @(posedge i_ref_clk);
    end
    if (exp_q.size() > 0) err_total++;
    stop_test();
  end
endmodule
